/* File: ctlr_params.svh */
// Constants shared by both ends of the trip latch and ramp block
`ifndef CTLR_PARAMS_SVH
`define CTLR_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CTLR_OFS_FILT   5'h00
`define CTLR_OFS_STAT   5'h04
`define CTLR_OFS_SCLR   5'h08
`define CTLR_OFS_RSTART 5'h0c
`define CTLR_OFS_RSTEP  5'h10
`define CTLR_OFS_DAC    5'h14
`define CTLR_OFS_ISTS   5'h18
`define CTLR_OFS_IMSK   5'h1c
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTLR_DIV_LSB    0
`define CTLR_DIV_MSB    9
`define CTLR_THR_LSB    10
`define CTLR_THR_MSB    14
`define CTLR_REINIT_BIT 31
`define CTLR_ST_FILT    0
`define CTLR_ST_LATCH   1
`define CTLR_ST_RUN     2
`define CTLR_CLR_BIT    0
`define CTLR_IRQ_TRIP   0
`define CTLR_IRQ_SYNC   1
// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define CTLR_HIST_W     16
`define CTLR_RST_DIV    10'h001
`define CTLR_RST_THR    5'h01
`define CTLR_RST_RSTART 16'hffff
`define CTLR_RST_RSTEP  16'h0001
`define CTLR_ONE_DIV    10'h001
`define CTLR_ONE_CNT    16'h0001
`endif

/* File: ctlr_pkg.sv */
// Types shared by both ends of the trip latch and ramp block
package ctlr_pkg;
    typedef logic [15:0] ctlr_dac_t;
    typedef enum logic [0:0] {
        CTLR_RAMP_HALT = 1'b0,
        CTLR_RAMP_RUN  = 1'b1
    } ctlr_ramp_e;
    typedef struct packed {
        logic [9:0]  filt_div;
        logic [4:0]  filt_thr;
        logic        samp;
        logic [9:0]  pcnt;
        logic [15:0] hist;
        logic        filt_out;
        logic        trip_latch;
        ctlr_ramp_e  ramp_st;
        ctlr_dac_t   dac;
        ctlr_dac_t   ramp_start;
        ctlr_dac_t   ramp_step;
        logic [1:0]  irq_sts;
        logic [1:0]  irq_msk;
        logic [31:0] rdata;
        logic        ack;
    } ctlr_dev_s;
    typedef struct packed {
        logic [15:0] cnt;
        logic        sync;
        logic        pwm_on;
    } ctlr_pwm_s;
endpackage

/* File: ctlr_link_if.sv */
// Link between the comparator back end and the PWM module
`timescale 1ns/1ps
interface ctlr_link_if;
    logic pwm_sync_pulse;
    logic trip_latch;
    modport dev (input pwm_sync_pulse, output trip_latch);
    modport pwm (output pwm_sync_pulse, input trip_latch);
endinterface

/* File: ctlr_pwm_end.sv */
// PWM module end: makes sync pulses and obeys the trip level
`timescale 1ns/1ps
`include "ctlr_params.svh"
module ctlr_pwm_end (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         srst,
    // Link
    ctlr_link_if.pwm          link,
    // User side
    input  wire logic [15:0]  pwm_period,
    input  wire logic [15:0]  pwm_duty,
    input  wire logic [15:0]  pwm_duty_cap,
    input  wire logic [15:0]  pwm_guard,
    output logic              pwm_out,
    output logic              pwm_tripped
);
    import ctlr_pkg::*;

    ctlr_pwm_s st;
    ctlr_pwm_s next_st;
    logic [15:0] on_len;
    logic [15:0] guard_len;

    // ----------------------------------------------------------------
    // On-time limit
    // ----------------------------------------------------------------
    // Capped duty keeps trips clear of the sync edge
    always_comb begin
        on_len = (pwm_duty < pwm_duty_cap) ? pwm_duty : pwm_duty_cap;
        guard_len = (pwm_period > pwm_guard) ? pwm_period - pwm_guard : 16'h0000;
        if (on_len > guard_len) begin
            on_len = guard_len;
        end
    end

    // ----------------------------------------------------------------
    // Period counter and output
    // ----------------------------------------------------------------
    // Sync is a one-cycle pulse at the start of each period
    always_comb begin
        next_st = st;
        next_st.sync = 1'b0;
        if (st.cnt >= pwm_period) begin
            next_st.cnt = 16'h0000;
            next_st.sync = 1'b1;
            next_st.pwm_on = (on_len != 16'h0000);
        end else begin
            next_st.cnt = st.cnt + `CTLR_ONE_CNT;
            if (next_st.cnt >= on_len || link.trip_latch) begin
                next_st.pwm_on = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.pwm_sync_pulse = st.sync;
    assign pwm_out = st.pwm_on;
    assign pwm_tripped = link.trip_latch;
endmodule

/* File: ctlr_comp_end.sv */
// Comparator back end: filter, trip latch, ramp and register slave
// Notes on behaviour
// - Latch holds until software clear or sync
// - Latch set only by filtered comparator
// - Worst delay is 3 plus thr times div
// - Filter path may stay stale after clear
// - Filter high at clear re-sets latch next cycle
// - Software checks filter low before clearing
// - Software may reinit filter to flush history
// - Trip ends one latency before sync clear
// - Ramp is a falling reference aligned to sync
// - Each sync with the filter low starts the ramp decrementing
// - High comparator status halts the ramp
// - Trip beats simultaneous sync; ramp stays halted
// - Keep trips away from sync pulses
`timescale 1ns/1ps
`include "ctlr_params.svh"
module ctlr_comp_end (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               srst,
    // Link to the PWM module
    ctlr_link_if.dev                link,
    // Comparator input
    input  wire logic               comp_raw,
    // Avalon-MM slave
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [3:0]         avs_byteenable,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // Outputs
    output ctlr_pkg::ctlr_dac_t     dac_value,
    output logic                    irq
);
    import ctlr_pkg::*;

    ctlr_dev_s   st;
    ctlr_dev_s   next_st;
    logic        req;
    logic        wr_go;
    logic [4:0]  adr;
    logic [31:0] be_mask;
    logic [31:0] wd;
    logic [31:0] filt_word;
    logic [4:0]  ones;
    logic [4:0]  win;
    logic        sample_now;
    logic        sclr;
    logic        trip_now;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Every access takes two cycles: request, then ack with data
    always_comb begin
        req = avs_read | avs_write;
        wr_go = avs_write & st.ack;
        adr = {avs_address[4:2], 2'b00};
        be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wd = avs_writedata & be_mask;
        filt_word = 32'h0000_0000;
        filt_word[`CTLR_DIV_MSB:`CTLR_DIV_LSB] = st.filt_div;
        filt_word[`CTLR_THR_MSB:`CTLR_THR_LSB] = st.filt_thr;
        sclr = wr_go && adr == `CTLR_OFS_SCLR && wd[`CTLR_CLR_BIT];
    end

    assign avs_waitrequest = req & ~st.ack;

    // ----------------------------------------------------------------
    // Filter vote
    // ----------------------------------------------------------------
    // Ones among the newest samples; a divider of zero acts as one
    // Window is the vote threshold, capped at the history depth
    always_comb begin
        win = (st.filt_thr > 5'(`CTLR_HIST_W)) ? 5'(`CTLR_HIST_W) : st.filt_thr;
        ones = 5'h00;
        for (int i = 0; i < `CTLR_HIST_W; i++) begin
            if (5'(i) < win) begin
                ones = ones + {4'h0, st.hist[i]};
            end
        end
        sample_now = (st.filt_div <= `CTLR_ONE_DIV) ||
                     (st.pcnt >= st.filt_div - `CTLR_ONE_DIV);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = req & ~st.ack;

        // Digitizer stage adds the fixed one cycle of delay
        next_st.samp = comp_raw;

        // Prescaled sampling and threshold vote
        if (sample_now) begin
            next_st.pcnt = 10'h000;
            next_st.hist = {st.hist[`CTLR_HIST_W-2:0], st.samp};
        end else begin
            next_st.pcnt = st.pcnt + `CTLR_ONE_DIV;
        end
        // Output moves only on a unanimous window, so rising and falling
        // share one latency and a clear sees stale data for at most that long
        if (st.filt_thr == 5'h00) begin
            next_st.filt_out = 1'b0;
        end else if (ones == win) begin
            next_st.filt_out = 1'b1;
        end else if (ones == 5'h00) begin
            next_st.filt_out = 1'b0;
        end

        // Latch: a clear wins this cycle; a high filter sets it next cycle
        trip_now = st.filt_out;
        if (sclr || link.pwm_sync_pulse) begin
            next_st.trip_latch = 1'b0;
        end else if (trip_now) begin
            next_st.trip_latch = 1'b1;
        end

        // Ramp: sync restarts it, status high halts it
        if (link.pwm_sync_pulse) begin
            next_st.dac = st.ramp_start;
            // Known quirk kept: a coincident trip leaves the ramp halted
            next_st.ramp_st = trip_now ? CTLR_RAMP_HALT : CTLR_RAMP_RUN;
        end else if (st.trip_latch) begin
            next_st.ramp_st = CTLR_RAMP_HALT;
        end else if (st.ramp_st == CTLR_RAMP_RUN) begin
            // Saturate at zero rather than wrap to full scale
            next_st.dac = (st.dac > st.ramp_step) ? st.dac - st.ramp_step : 16'h0000;
        end

        // Sticky events; a new event beats a same-cycle clear
        if (wr_go && adr == `CTLR_OFS_ISTS) begin
            next_st.irq_sts = st.irq_sts & ~wd[1:0];
        end
        if (~st.trip_latch & next_st.trip_latch) begin
            next_st.irq_sts[`CTLR_IRQ_TRIP] = 1'b1;
        end
        if (link.pwm_sync_pulse) begin
            next_st.irq_sts[`CTLR_IRQ_SYNC] = 1'b1;
        end

        // Register writes take effect on the ack edge
        if (wr_go) begin
            case (adr)
                `CTLR_OFS_FILT: begin
                    next_st.filt_div = (st.filt_div & ~be_mask[`CTLR_DIV_MSB:`CTLR_DIV_LSB])
                                     | wd[`CTLR_DIV_MSB:`CTLR_DIV_LSB];
                    next_st.filt_thr = (st.filt_thr & ~be_mask[`CTLR_THR_MSB:`CTLR_THR_LSB])
                                     | wd[`CTLR_THR_MSB:`CTLR_THR_LSB];
                    // Flush history so a long latency need not be waited out
                    if (wd[`CTLR_REINIT_BIT]) begin
                        next_st.hist = '0;
                        next_st.pcnt = 10'h000;
                        next_st.filt_out = 1'b0;
                    end
                end
                `CTLR_OFS_RSTART: begin
                    next_st.ramp_start = (st.ramp_start & ~be_mask[15:0]) | wd[15:0];
                end
                `CTLR_OFS_RSTEP: begin
                    next_st.ramp_step = (st.ramp_step & ~be_mask[15:0]) | wd[15:0];
                end
                `CTLR_OFS_IMSK: begin
                    next_st.irq_msk = (st.irq_msk & ~be_mask[1:0]) | wd[1:0];
                end
                default: begin
                end
            endcase
        end

        // Read data is captured in the request cycle
        if (avs_read & ~st.ack) begin
            case (adr)
                `CTLR_OFS_FILT:   next_st.rdata = filt_word;
                `CTLR_OFS_STAT:   next_st.rdata = {29'h0, st.ramp_st == CTLR_RAMP_RUN,
                                                   st.trip_latch, st.filt_out};
                `CTLR_OFS_RSTART: next_st.rdata = {16'h0000, st.ramp_start};
                `CTLR_OFS_RSTEP:  next_st.rdata = {16'h0000, st.ramp_step};
                `CTLR_OFS_DAC:    next_st.rdata = {16'h0000, st.dac};
                `CTLR_OFS_ISTS:   next_st.rdata = {30'h0, st.irq_sts};
                `CTLR_OFS_IMSK:   next_st.rdata = {30'h0, st.irq_msk};
                default:          next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= '0;
            st.filt_div <= `CTLR_RST_DIV;
            st.filt_thr <= `CTLR_RST_THR;
            st.ramp_start <= `CTLR_RST_RSTART;
            st.ramp_step <= `CTLR_RST_RSTEP;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign avs_readdata = st.rdata;
    assign dac_value = st.dac;
    assign irq = |(st.irq_sts & st.irq_msk);
    assign link.trip_latch = st.trip_latch;
endmodule

/* File: ctlr_assertions.sv */
// Checks on the trip link, the ramp output and the bus handshake
`timescale 1ns/1ps
module ctlr_assertions #(
    parameter int LAT = 9
) (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                srst,
    // Link and watched ports
    input wire logic                pwm_sync_pulse,
    input wire logic                trip_latch,
    input wire logic                comp_raw,
    input wire ctlr_pkg::ctlr_dac_t dac_value,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic                avs_waitrequest
);
    import ctlr_pkg::*;
    // ----------------------------------------
    // Comparator high-run and quiet counters
    // ----------------------------------------
    logic [7:0] run;
    logic [7:0] quiet;
    // Saturating, so a long hold never wraps back to a short count
    always_ff @(posedge clk_sys) begin
        run <= (srst || !comp_raw) ? 8'h00 : run + {7'h00, run != 8'hff};
        quiet <= (srst || comp_raw) ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Latch, ramp and bus relations
    latch_hold_a: assert property ($fell(trip_latch) |->
        $past(pwm_sync_pulse) || $past(avs_write && !avs_waitrequest))
        else $error("trip latch fell with no clear");
    latch_cause_a: assert property ($rose(trip_latch) |->
        run != 8'h00 || quiet < 8'(2 * LAT + 4))
        else $error("trip latch set with comparator quiet");
    latch_delay_a: assert property (run == 8'(LAT) |->
        ##[0:3] trip_latch)
        else $error("trip latch too slow");
    latch_reset_a: assert property ($fell(trip_latch) && run > 8'(LAT + 2) |=>
        trip_latch)
        else $error("trip latch not set again after clear");
    ramp_start_a: assert property (pwm_sync_pulse && quiet > 8'(2 * LAT) |->
        ##2 (dac_value < $past(dac_value) || dac_value == 16'h0000))
        else $error("ramp did not fall after sync");
    ramp_halt_a: assert property ((trip_latch && !pwm_sync_pulse) [*2] |=>
        $stable(dac_value))
        else $error("ramp moved while tripped");
    ramp_collide_a: assert property (pwm_sync_pulse && run > 8'(LAT + 2) |->
        ##2 $stable(dac_value) [*3])
        else $error("ramp ran after trip at sync");
    bus_wait_a: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    // Main scenarios reached
    cover property ($rose(trip_latch));
    cover property (pwm_sync_pulse && trip_latch);
    cover property (pwm_sync_pulse && run > 8'(LAT + 2));
endmodule

/* File: ctlr_tb_top.sv */
// Bench joining the comparator end and the PWM end through the link
`timescale 1ns/1ps
`include "ctlr_params.svh"
module ctlr_tb_top;
    import ctlr_pkg::*;
    localparam int LAT = 9; // Divider 2, threshold 3
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        comp_raw = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    ctlr_dac_t   dac_value;
    ctlr_dac_t   start;
    logic        irq;
    logic        pwm_out;
    logic        pwm_tripped;
    logic [31:0] exq[$];
    int          fails = 0;
    int          num_checks = 0;
    int          seed = 32;
    ctlr_link_if u_ctlr_link_if ();
    ctlr_comp_end u_ctlr_comp_end (.clk_sys, .srst, .link(u_ctlr_link_if), .comp_raw,
        .avs_address, .avs_read, .avs_write, .avs_byteenable(4'hf), .avs_writedata,
        .avs_readdata, .avs_waitrequest, .dac_value, .irq);
    // Period 200 cycles leaves room for a whole test between syncs
    ctlr_pwm_end u_ctlr_pwm_end (.clk_sys, .srst, .link(u_ctlr_link_if),
        .pwm_period(16'h00c7), .pwm_duty(16'h003c), .pwm_duty_cap(16'h0050),
        .pwm_guard(16'h000a), .pwm_out, .pwm_tripped);
    ctlr_assertions #(.LAT(LAT)) u_ctlr_assertions (.clk_sys, .srst,
        .pwm_sync_pulse(u_ctlr_link_if.pwm_sync_pulse),
        .trip_latch(u_ctlr_link_if.trip_latch), .comp_raw, .dac_value,
        .avs_read, .avs_write, .avs_waitrequest);
    always #5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Ramp reference against its expected value
    task automatic chk_dac(input ctlr_dac_t exp);
        chk({16'h0, dac_value}, {16'h0, exp});
    endtask
    // Single level outputs such as the interrupt and PWM pins
    task automatic chk_pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // Request stands until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys iff avs_waitrequest === 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wsync();
        @(posedge clk_sys iff u_ctlr_link_if.pwm_sync_pulse === 1'b1);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Answered reads retire the oldest expectation
    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest === 1'b0)
            chk(avs_readdata, exq.pop_front());
    end
    // Hang guard, well past the four sync periods used
    initial begin
        repeat (4000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        rd(`CTLR_OFS_FILT, 32'h0000_0401);
        rd(`CTLR_OFS_RSTART, 32'h0000_ffff);
        rd(`CTLR_OFS_STAT, 32'h0);
        start = 16'($random(seed)) | 16'h1000;
        bus(1'b1, `CTLR_OFS_FILT, 32'h0000_0c02);
        bus(1'b1, `CTLR_OFS_RSTART, {16'h0, start});
        bus(1'b1, `CTLR_OFS_RSTEP, 32'h10);
        bus(1'b1, `CTLR_OFS_IMSK, 32'h1);
        $display("test reset done");
        wsync();
        chk_dac(start);
        @(posedge clk_sys);
        #1;
        chk_dac(start - 16'h0010);
        $display("test ramp done");
        repeat (5) @(posedge clk_sys);
        comp_raw <= 1'b1;
        repeat (LAT + 4 + ($random(seed) & 7)) @(posedge clk_sys);
        rd(`CTLR_OFS_STAT, 32'h3);
        comp_raw <= 1'b0;
        // Filter must settle low within one latency of the trip ending
        repeat (LAT) @(posedge clk_sys);
        rd(`CTLR_OFS_STAT, 32'h2);
        rd(`CTLR_OFS_ISTS, 32'h3);
        chk_pin(irq, 1'b1);
        bus(1'b1, `CTLR_OFS_IMSK, 32'h0);
        #1;
        chk_pin(irq, 1'b0);
        bus(1'b1, `CTLR_OFS_IMSK, 32'h1);
        bus(1'b1, `CTLR_OFS_ISTS, 32'h3);
        #1;
        chk_pin(irq, 1'b0);
        rd(`CTLR_OFS_STAT, 32'h2);
        bus(1'b1, `CTLR_OFS_SCLR, 32'h1);
        rd(`CTLR_OFS_STAT, 32'h0);
        $display("test latch done");
        wsync();
        @(posedge clk_sys);
        comp_raw <= 1'b1;
        repeat (LAT + 4) @(posedge clk_sys);
        bus(1'b1, `CTLR_OFS_SCLR, 32'h1);
        rd(`CTLR_OFS_STAT, 32'h3);
        comp_raw <= 1'b0;
        bus(1'b1, `CTLR_OFS_FILT, 32'h8000_0c02);
        rd(`CTLR_OFS_STAT, 32'h2);
        bus(1'b1, `CTLR_OFS_SCLR, 32'h1);
        rd(`CTLR_OFS_STAT, 32'h0);
        $display("test refire done");
        comp_raw <= 1'b1;
        wsync();
        chk_dac(start);
        repeat (3) @(posedge clk_sys);
        #1;
        chk_dac(start);
        chk_pin(pwm_out, 1'b0);
        chk_pin(pwm_tripped, 1'b1);
        @(posedge clk_sys);
        comp_raw <= 1'b0;
        $display("test collide done");
        wsync();
        rd(`CTLR_OFS_STAT, 32'h4);
        $display("test sync clear done");
        print_verdict();
    end
endmodule
